// file: inc/lpms_params.svh
// constants of the lighting power mode sequencer
`ifndef LPMS_PARAMS_SVH
`define LPMS_PARAMS_SVH

// clock and delay timing
`define LPMS_CLK_KHZ 100000
`define LPMS_CLK_PERIOD_NS 10
`define LPMS_STARTUP_MS 10
`define LPMS_SOFTSTART_MS 20
`define LPMS_STARTUP_CYC (`LPMS_STARTUP_MS * `LPMS_CLK_KHZ)
`define LPMS_SOFTSTART_CYC (`LPMS_SOFTSTART_MS * `LPMS_CLK_KHZ)

// boost switching timing
`define LPMS_PWM_KHZ 1000
`define LPMS_PWM_PERIOD_CYC (`LPMS_CLK_KHZ / `LPMS_PWM_KHZ)
`define LPMS_MIN_PULSE_NS 45
`define LPMS_MIN_PULSE_CYC ((`LPMS_MIN_PULSE_NS + `LPMS_CLK_PERIOD_NS - 1) / `LPMS_CLK_PERIOD_NS)
`define LPMS_MAX_DUTY_CYC 90
`define LPMS_SOFT_DUTY_CYC 30

// register offsets
`define LPMS_ADDR_BOOST_LEVEL 8'h0D
`define LPMS_ADDR_MODE_CTRL 8'h10
`define LPMS_ADDR_STATUS 8'h11

// control field positions
`define LPMS_CTRL_NOT_STANDBY_BIT_BIT 0
`define LPMS_CTRL_BOOST_EN_BIT 1
`define LPMS_CTRL_AUTOLOAD_BIT 2
`define LPMS_CTRL_MASK 8'h07

// reset values and level clamp
`define LPMS_CTRL_RESET 8'h04
`define LPMS_LEVEL_RESET 8'h08
`define LPMS_LEVEL_MIN 8'h08
`define LPMS_LEVEL_MAX 8'h12

`endif

// file: inc/lpms_pkg.sv
// types of the lighting power mode sequencer
`default_nettype none

package lpms_pkg;

  // operating modes
  typedef enum logic [2:0] {
    mode_reset,
    mode_standby,
    mode_startup,
    mode_boost_start,
    mode_normal
  } lpms_mode_type;

  // synchronised analog indications
  typedef struct packed {
    logic thermal_shutdown;
    logic over_current;
    logic over_voltage;
    logic feedback_break;
    logic current_peak;
    logic feedback_input_low;
  } lpms_prot_type;

  // register write from the serial interface
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } lpms_reg_wr_type;

  // power domain enables
  typedef struct packed {
    logic analog_enable;
    logic chip_enable;
    logic boost_run;
    logic soft_start;
    logic led_force_off;
    logic active_load;
  } lpms_pwr_type;

endpackage : lpms_pkg

`default_nettype wire

// file: hw/lpms_top.sv
// mode sequencer and boost digital control
//
// Summary of operation
// - reset mode returns every internal register to default
// - reset whenever external reset is low or power-on reset is high
// - after power-on reset releases the device goes to standby
// - not-standby bit reads zero after reset
// - standby while not-standby low and no reset; all functions off
// - writes accepted in standby and take effect at once
// - not-standby high runs startup with a 10ms delay
// - thermal shutdown holds the device in startup until it clears
// - boost soft start runs low-current PWM for 20ms
// - every LED output forced off during soft start
// - soft start after startup with boost on, or on boost enable rise
// - any register, any number of bits, in any order
// - 8-bit register selects the boost output level
// - active-load bit off: load off, pulse skipping allowed
// - active-load bit on: at least one minimum-length pulse every cycle
// - duty cycle limited by digital logic
// - over-current turns the switch off for the cycle
// - over-voltage inhibits switching
// - feedback break stops switching
// - level below 8 is used as 8
// - level above 18 is used as 18
// - boost enable low puts only the converter in standby
`include "lpms_params.svh"
`timescale 1ns/1ns
`default_nettype none

module lpms_top #(
  parameter int STARTUP_CYCLES = `LPMS_STARTUP_CYC,
  parameter int SOFTSTART_CYCLES = `LPMS_SOFTSTART_CYC,
  parameter int CNT_W = 21,
  parameter int PWM_PERIOD = `LPMS_PWM_PERIOD_CYC,
  parameter int PWM_W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // reset pins
  input wire logic external_reset_n_in,
  input wire logic power_on_reset_in,
  // analog indications
  input wire lpms_pkg::lpms_prot_type prot_in,
  // register port
  input wire lpms_pkg::lpms_reg_wr_type reg_wr_in,
  input wire logic [7:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  // power control
  output lpms_pkg::lpms_pwr_type pwr_out,
  output logic power_switch_drive_out,
  output logic [7:0] boost_level_out,
  output lpms_pkg::lpms_mode_type mode_out
);

  // elaboration checks
  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (2 ** CNT_W))
  begin : g_bad_startup
    $error("startup count out of range");
  end
  if (SOFTSTART_CYCLES < 1 || SOFTSTART_CYCLES >= (2 ** CNT_W))
  begin : g_bad_soft
    $error("soft start count out of range");
  end
  if (PWM_PERIOD <= `LPMS_MAX_DUTY_CYC || PWM_PERIOD > (2 ** PWM_W))
  begin : g_bad_period
    $error("switching period out of range");
  end

  localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] SOFT_LAST = CNT_W'(SOFTSTART_CYCLES - 1);
  localparam logic [PWM_W-1:0] PWM_LAST = PWM_W'(PWM_PERIOD - 1);
  localparam logic [PWM_W-1:0] MIN_PULSE = PWM_W'(`LPMS_MIN_PULSE_CYC);
  localparam logic [PWM_W-1:0] DUTY_FULL = PWM_W'(`LPMS_MAX_DUTY_CYC);
  localparam logic [PWM_W-1:0] DUTY_SOFT = PWM_W'(`LPMS_SOFT_DUTY_CYC);

  ////////////////////////////////////////////////////////////////////
  // reset synchroniser

  logic rst_async;
  logic [1:0] rst_sync;
  logic rst_int;

  // either pin forces reset at once
  assign rst_async = !external_reset_n_in || power_on_reset_in;

  // async set, clocked release
  always_ff @(posedge clk_in or posedge rst_async)
  begin
    if (rst_async)
      rst_sync <= 2'h3;
    else
      rst_sync <= {rst_sync[0], 1'b0};
  end

  assign rst_int = rst_sync[1] || srst_in;

  ////////////////////////////////////////////////////////////////////
  // input synchroniser

  lpms_pkg::lpms_prot_type prot_meta;
  lpms_pkg::lpms_prot_type prot_s;

  // two stages on the analog comparators
  always_ff @(posedge clk_in)
  begin
    prot_meta <= prot_in;
    prot_s <= prot_meta;
  end

  ////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] ctrl;
  logic [7:0] level;
  logic boost_en_prev;
  logic [7:0] next_ctrl;
  logic [7:0] next_level;
  logic next_boost_en_prev;
  logic [7:0] next_rd_data;
  logic not_standby_bit;
  logic boost_en;
  logic autoload;
  lpms_pkg::lpms_mode_type mode;

  assign not_standby_bit = ctrl[`LPMS_CTRL_NOT_STANDBY_BIT_BIT];
  assign boost_en = ctrl[`LPMS_CTRL_BOOST_EN_BIT];
  assign autoload = ctrl[`LPMS_CTRL_AUTOLOAD_BIT];

  // write decode, read mux
  always_comb
  begin
    next_ctrl = ctrl;
    next_level = level;
    next_boost_en_prev = boost_en;
    if (rst_int || mode == lpms_pkg::mode_reset)
    begin
      next_ctrl = `LPMS_CTRL_RESET;
      next_level = `LPMS_LEVEL_RESET;
      next_boost_en_prev = 1'b0;
    end
    else if (reg_wr_in.wr)
    begin
      // whole byte replaced per write, standby included
      if (reg_wr_in.addr == `LPMS_ADDR_BOOST_LEVEL)
        next_level = reg_wr_in.data;
      if (reg_wr_in.addr == `LPMS_ADDR_MODE_CTRL)
        next_ctrl = reg_wr_in.data & `LPMS_CTRL_MASK;
    end
    unique case (rd_addr_in)
      `LPMS_ADDR_BOOST_LEVEL: next_rd_data = level;
      `LPMS_ADDR_MODE_CTRL: next_rd_data = ctrl;
      `LPMS_ADDR_STATUS: next_rd_data = {3'h0, prot_s.thermal_shutdown,
                                         power_switch_drive_out, mode};
      default: next_rd_data = 8'h00;
    endcase
  end

  // register stage
  always_ff @(posedge clk_in)
  begin
    ctrl <= next_ctrl;
    level <= next_level;
    boost_en_prev <= next_boost_en_prev;
    rd_data_out <= next_rd_data;
  end

  ////////////////////////////////////////////////////////////////////
  // level clamp

  logic [7:0] next_boost_level;

  // out-of-range codes pinned to the ends
  always_comb
  begin
    next_boost_level = level;
    if (level < `LPMS_LEVEL_MIN)
      next_boost_level = `LPMS_LEVEL_MIN;
    else if (level > `LPMS_LEVEL_MAX)
      next_boost_level = `LPMS_LEVEL_MAX;
  end

  always_ff @(posedge clk_in)
  begin
    boost_level_out <= next_boost_level;
  end

  ////////////////////////////////////////////////////////////////////
  // mode state machine

  lpms_pkg::lpms_mode_type next_mode;
  logic [CNT_W-1:0] tmr;
  logic [CNT_W-1:0] next_tmr;
  lpms_pkg::lpms_pwr_type next_pwr;

  // mode sequence and delay timer
  always_comb
  begin
    next_mode = mode;
    next_tmr = tmr;
    if (rst_int)
      next_mode = lpms_pkg::mode_reset;
    else
    begin
      unique case (mode)
        lpms_pkg::mode_reset:
          next_mode = lpms_pkg::mode_standby;
        lpms_pkg::mode_standby:
          if (not_standby_bit)
            next_mode = lpms_pkg::mode_startup;
        lpms_pkg::mode_startup:
          if (prot_s.thermal_shutdown)
            next_tmr = '0;
          else if (tmr == STARTUP_LAST)
            next_mode = boost_en ? lpms_pkg::mode_boost_start
                                 : lpms_pkg::mode_normal;
          else
            next_tmr = tmr + 1'b1;
        lpms_pkg::mode_boost_start:
          if (!boost_en)
            next_mode = lpms_pkg::mode_normal;
          else if (tmr == SOFT_LAST)
            next_mode = lpms_pkg::mode_normal;
          else
            next_tmr = tmr + 1'b1;
        lpms_pkg::mode_normal:
          if (boost_en && !boost_en_prev)
            next_mode = lpms_pkg::mode_boost_start;
      endcase
      // overrides for any running mode
      if (mode != lpms_pkg::mode_reset && !not_standby_bit)
        next_mode = lpms_pkg::mode_standby;
      else if (prot_s.thermal_shutdown &&
               (mode == lpms_pkg::mode_boost_start ||
                mode == lpms_pkg::mode_normal))
        next_mode = lpms_pkg::mode_startup;
    end
    if (next_mode != mode)
      next_tmr = '0;
    // enables follow the next mode
    next_pwr.analog_enable = next_mode == lpms_pkg::mode_startup ||
                             next_mode == lpms_pkg::mode_boost_start ||
                             next_mode == lpms_pkg::mode_normal;
    next_pwr.chip_enable = next_mode == lpms_pkg::mode_boost_start ||
                           next_mode == lpms_pkg::mode_normal;
    next_pwr.soft_start = next_mode == lpms_pkg::mode_boost_start;
    next_pwr.boost_run = next_pwr.soft_start ||
                         (next_mode == lpms_pkg::mode_normal &&
                          next_ctrl[`LPMS_CTRL_BOOST_EN_BIT]);
    next_pwr.led_force_off = next_mode != lpms_pkg::mode_normal;
    next_pwr.active_load = next_pwr.boost_run &&
                           next_ctrl[`LPMS_CTRL_AUTOLOAD_BIT];
  end

  // register stage
  always_ff @(posedge clk_in)
  begin
    mode <= next_mode;
    tmr <= next_tmr;
    pwr_out <= next_pwr;
  end

  assign mode_out = mode;

  ////////////////////////////////////////////////////////////////////
  // boost switch control

  logic [PWM_W-1:0] pwm_cnt;
  logic [PWM_W-1:0] next_pwm_cnt;
  logic next_sw;
  logic [PWM_W-1:0] duty_lim;
  logic sw_block;

  // soft start uses a lower ceiling
  assign duty_lim = pwr_out.soft_start ? DUTY_SOFT : DUTY_FULL;
  assign sw_block = prot_s.over_voltage || prot_s.feedback_break;

  // one pulse per period, ended by limits
  always_comb
  begin
    next_sw = power_switch_drive_out;
    next_pwm_cnt = (pwm_cnt == PWM_LAST) ? '0 : pwm_cnt + 1'b1;
    if (!pwr_out.boost_run)
    begin
      next_sw = 1'b0;
      next_pwm_cnt = '0;
    end
    else if (pwm_cnt == '0)
      next_sw = !sw_block &&
                (prot_s.feedback_input_low || autoload);
    else if (power_switch_drive_out)
    begin
      if (prot_s.over_current || sw_block)
        next_sw = 1'b0;
      else if (pwm_cnt >= duty_lim)
        next_sw = 1'b0;
      else if (pwm_cnt >= MIN_PULSE &&
               (prot_s.current_peak || !prot_s.feedback_input_low))
        next_sw = 1'b0;
    end
  end

  // register stage
  always_ff @(posedge clk_in)
  begin
    if (rst_int)
    begin
      power_switch_drive_out <= 1'b0;
      pwm_cnt <= '0;
    end
    else
    begin
      power_switch_drive_out <= next_sw;
      pwm_cnt <= next_pwm_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // assertions

  a_reset_mode: assert property (@(posedge clk_in) rst_int |=> mode == lpms_pkg::mode_reset)
    else $error("reset did not force reset mode");

  a_reset_regs: assert property (@(posedge clk_in) mode == lpms_pkg::mode_reset
    |=> ctrl == `LPMS_CTRL_RESET && level == `LPMS_LEVEL_RESET)
    else $error("registers not defaulted in reset");

  a_standby_entry: assert property (@(posedge clk_in) disable iff (rst_int)
    mode != lpms_pkg::mode_reset && !not_standby_bit |=> mode == lpms_pkg::mode_standby)
    else $error("standby not entered");

  a_standby_quiet: assert property (@(posedge clk_in) disable iff (rst_int)
    mode == lpms_pkg::mode_standby ##1 mode == lpms_pkg::mode_standby
    |-> !pwr_out.analog_enable && !power_switch_drive_out)
    else $error("standby not quiet");

  a_thermal_shutdown_hold: assert property (@(posedge clk_in) disable iff (rst_int)
    prot_s.thermal_shutdown && not_standby_bit && mode != lpms_pkg::mode_reset
    && mode != lpms_pkg::mode_standby |=> mode == lpms_pkg::mode_startup)
    else $error("thermal event left startup");

  a_startup_exit: assert property (@(posedge clk_in) disable iff (rst_int)
    mode == lpms_pkg::mode_startup && tmr == STARTUP_LAST && not_standby_bit
    && !prot_s.thermal_shutdown |=> mode != lpms_pkg::mode_startup)
    else $error("startup delay overran");

  a_soft_leds: assert property (@(posedge clk_in) disable iff (rst_int)
    mode == lpms_pkg::mode_boost_start |-> pwr_out.led_force_off)
    else $error("leds on during soft start");

  a_level_clamp: assert property (@(posedge clk_in) disable iff (rst_int)
    ##1 boost_level_out >= `LPMS_LEVEL_MIN && boost_level_out <= `LPMS_LEVEL_MAX)
    else $error("boost level outside clamp");

  a_oc_off: assert property (@(posedge clk_in) disable iff (rst_int)
    power_switch_drive_out && prot_s.over_current && pwm_cnt != '0
    |=> !power_switch_drive_out)
    else $error("switch kept on in over-current");

  a_ov_inhibit: assert property (@(posedge clk_in) disable iff (rst_int)
    $past(sw_block) |-> !power_switch_drive_out)
    else $error("switching while inhibited");

  a_duty_limit: assert property (@(posedge clk_in) disable iff (rst_int)
    power_switch_drive_out |-> pwm_cnt <= duty_lim + 1'b1)
    else $error("duty limit exceeded");

endmodule : lpms_top

`default_nettype wire

// file: dv/lpms_host.sv
// host side register master driving the sequencer register port
`timescale 1ns/1ns
`default_nettype none

module lpms_host (
  // clock
  input wire logic clk_in,
  // register port
  output lpms_pkg::lpms_reg_wr_type reg_wr_out,
  output logic [7:0] rd_addr_out,
  input wire logic [7:0] rd_data_in
);
  // idle port at time zero
  initial
  begin
    reg_wr_out = '0;
    rd_addr_out = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////
  // one-cycle write, any register in any order, released to inverse
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_wr_out = {1'b1, a, d};
    @(negedge clk_in);
    reg_wr_out = {1'b0, ~a, ~d};
  endtask : write

  // read data lands one cycle after the address
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    rd_addr_out = a;
    @(negedge clk_in);
    d = rd_data_in;
  endtask : read
endmodule : lpms_host

`default_nettype wire

// file: dv/test_lpms_top.sv
// self-checking bench of the lighting power mode sequencer
`timescale 1ns/1ns
`default_nettype none

module test_lpms_top;
  localparam int SU = 20;
  localparam int SS = 40;
  typedef struct {logic [7:0] wr; logic [7:0] lvl;} lpms_row_type;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic external_reset_n_in = 1'b1;
  logic power_on_reset_in = 1'b0;
  lpms_pkg::lpms_prot_type prot_in = '0;
  lpms_pkg::lpms_reg_wr_type reg_wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  lpms_pkg::lpms_pwr_type pwr;
  logic sw;
  logic [7:0] level;
  lpms_pkg::lpms_mode_type mode;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int cnt;
  logic [7:0] rd;
  lpms_row_type rows [7] = '{'{8'h00, 8'h08}, '{8'h07, 8'h08}, '{8'h08, 8'h08},
    '{8'h0C, 8'h0C}, '{8'h12, 8'h12}, '{8'h13, 8'h12}, '{8'hFF, 8'h12}};

  //////////////////////////////////////////////////////////////////////
  // design, host model and clock
  lpms_top #(.STARTUP_CYCLES(SU), .SOFTSTART_CYCLES(SS)) dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .external_reset_n_in(external_reset_n_in),
    .power_on_reset_in(power_on_reset_in), .prot_in(prot_in), .reg_wr_in(reg_wr),
    .rd_addr_in(rd_addr), .rd_data_out(rd_data), .pwr_out(pwr),
    .power_switch_drive_out(sw), .boost_level_out(level), .mode_out(mode));
  lpms_host host_u (.clk_in(clk_in), .reg_wr_out(reg_wr), .rd_addr_out(rd_addr), .rd_data_in(rd_data));
  always #5 clk_in = ~clk_in;

  // hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // wait for a mode, its arrival bounded on both sides
  task automatic wait_mode(input lpms_pkg::lpms_mode_type m, input int lo, input int hi);
    int n;
    n = 0;
    while (mode !== m && n <= hi)
    begin
      @(negedge clk_in);
      n++;
    end
    chk(8'(n >= lo && n <= hi), 8'h01, "mode timing");
  endtask : wait_mode

  // count switch-on cycles in a window
  task automatic win(input int n);
    cnt = 0;
    repeat (n)
    begin
      @(negedge clk_in);
      cnt += int'(sw === 1'b1);
    end
  endtask : win

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk(8'(mode), 8'h01, "standby after reset");
    chk(8'(pwr.analog_enable), 8'h00, "analog off in standby");
    host_u.read(8'h10, rd);
    chk(rd, 8'h04, "ctrl default");
    host_u.read(8'h0D, rd);
    chk(rd, 8'h08, "level default");
    host_u.read(8'h20, rd);
    chk(rd, 8'h00, "unmapped read");
    // stored in standby, bring up with boost
    host_u.write(8'h0D, 8'h0C);
    host_u.write(8'h10, 8'h07);
    wait_mode(lpms_pkg::mode_startup, 0, 3);
    chk(8'(pwr.analog_enable), 8'h01, "analog on in startup");
    wait_mode(lpms_pkg::mode_boost_start, SU - 3, SU + 3);
    chk(8'(pwr.led_force_off), 8'h01, "leds off in soft start");
    chk(8'(pwr.soft_start), 8'h01, "soft start flag");
    wait_mode(lpms_pkg::mode_normal, SS - 3, SS + 3);
    chk(8'(pwr.led_force_off), 8'h00, "leds free in normal");
    chk(8'(pwr.chip_enable), 8'h01, "chip on in normal");
    chk(8'(pwr.active_load), 8'h01, "active load on");
    chk(level, 8'h0C, "standby write effective");
    // level register and clamp
    foreach (rows[i])
    begin
      host_u.write(8'h0D, rows[i].wr);
      host_u.read(8'h0D, rd);
      chk(rd, rows[i].wr, "level readback");
      repeat (2) @(negedge clk_in);
      chk(level, rows[i].lvl, "clamped level");
    end
    // duty ceiling, minimum pulse, active load off
    // one settling period before the duty and minimum pulse windows
    prot_in = 6'b000001;
    win(100);
    win(100);
    chk(8'(cnt >= 80 && cnt <= 90), 8'h01, "duty limit");
    prot_in = 6'b000000;
    win(100);
    win(100);
    chk(8'(cnt >= 5 && cnt <= 10), 8'h01, "minimum pulse");
    host_u.write(8'h10, 8'h03);
    chk(8'(pwr.active_load), 8'h00, "active load off");
    repeat (10) @(negedge clk_in);
    win(200);
    chk(8'(cnt), 8'h00, "pulses skipped");
    host_u.write(8'h10, 8'h07);
    // over-voltage and feedback break inhibit switching
    for (int k = 0; k < 2; k++)
    begin
      prot_in = k ? 6'b000101 : 6'b001001;
      repeat (4) @(negedge clk_in);
      win(200);
      chk(8'(cnt), 8'h00, "switching inhibited");
    end
    // over-current cuts the running pulse
    prot_in = 6'b000001;
    win(100);
    // align to a pulse start so the cut lands inside a running pulse
    @(posedge sw);
    @(negedge clk_in);
    prot_in = 6'b010001;
    repeat (4) @(negedge clk_in);
    chk(8'(sw), 8'h00, "over current off");
    win(100);
    chk(8'(cnt), 8'h01, "one on cycle per period");
    prot_in = 6'b000000;
    // converter standby, re-entry on enable rise
    host_u.write(8'h10, 8'h05);
    repeat (3) @(negedge clk_in);
    chk(8'(mode), 8'h04, "chip stays normal");
    chk(8'(pwr.boost_run), 8'h00, "boost stopped");
    host_u.write(8'h10, 8'h07);
    wait_mode(lpms_pkg::mode_boost_start, 0, 4);
    wait_mode(lpms_pkg::mode_normal, SS - 4, SS + 4);
    // thermal holds startup
    prot_in = 6'b100000;
    wait_mode(lpms_pkg::mode_startup, 1, 5);
    repeat (3 * SU) @(negedge clk_in);
    chk(8'(mode), 8'h02, "held in startup");
    chk(8'(pwr.chip_enable), 8'h00, "chip off in thermal hold");
    host_u.read(8'h11, rd);
    chk(rd, 8'h12, "status in thermal hold");
    prot_in = 6'b000000;
    wait_mode(lpms_pkg::mode_boost_start, SU - 3, SU + 6);
    // not-standby low
    host_u.write(8'h10, 8'h06);
    wait_mode(lpms_pkg::mode_standby, 0, 4);
    chk(8'(pwr.analog_enable), 8'h00, "analog off again");
    // external reset and power-on reset
    for (int k = 0; k < 2; k++)
    begin
      host_u.write(8'h0D, 8'h10);
      external_reset_n_in = k[0];
      power_on_reset_in = k[0];
      wait_mode(lpms_pkg::mode_reset, 0, 3);
      @(negedge clk_in);
      external_reset_n_in = 1'b1;
      power_on_reset_in = 1'b0;
      wait_mode(lpms_pkg::mode_standby, 1, 5);
      host_u.read(8'h10, rd);
      chk(rd, 8'h04, "ctrl after reset");
      host_u.read(8'h0D, rd);
      chk(rd, 8'h08, "level after reset");
    end
    give_verdict();
  end
endmodule : test_lpms_top

`default_nettype wire
